// File: shared/pin_mux_pkg.sv
// Purpose: Constants and carriers for the port A/B pin multiplexer
// Assumes: Configuration bits arrive as plain ports, one clock domain
// Notes: Field positions name bits inside the configuration bytes
package pin_mux_pkg;
  // Interface configuration field encodings
  localparam logic [1:0] IFC_PORTS = 2'h0;
  localparam logic [1:0] IFC_RESVD = 2'h1;
  localparam logic [1:0] IFC_MASTER = 2'h2;
  localparam logic [1:0] IFC_SLAVE = 2'h3;
  // FIFO pin polarity byte
  localparam int POL_OE_BIT = 4;
  localparam int POL_COMMIT_BIT = 5;
  // Wakeup control byte
  localparam int WAKE_EN_BIT = 1;
  localparam int WAKE_POL_BIT = 4;
  localparam int WAKE_PA3_SEL_BIT = 7;
  // Port A output-enable and function bytes
  localparam int PA3_OE_BIT = 3;
  localparam int PA7_CFG_BIT = 7;
  // Pin positions of the covered port A pins
  localparam int PA_PIN2 = 2;
  localparam int PA_PIN3 = 3;
  localparam int PA_PIN4 = 4;
  localparam int PA_PIN5 = 5;
  localparam int PA_PIN6 = 6;
  localparam int PA_PIN7 = 7;
  localparam int PB_LOW_BITS = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [1:0] interface_config_field;
    logic [7:0] fifo_pin_polarity_reg;
    logic [7:0] wake_ctrl;
    logic [7:0] porta_output_enable_reg;
    logic [7:0] porta_function_config;
    logic [7:0] portb_output_enable;
  } mux_cfg_s;

  typedef struct packed {
    logic slave_output_enable_in;
    logic fifo_select_bit1;
    logic fifo_select_bit0;
    logic packet_commit_in;
    logic slave_chip_select_n;
  } fifo_ctl_s;
endpackage

// File: hw/wake_detect.sv
// Purpose: Second wakeup source edge and level detection
// Assumes: Pin input synchronous to the clock
// Notes: Level is seen after polarity correction; transition is any change of the raw pin
`timescale 1ns/100ps
module wake_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic enable,
  input wire logic polarity,
  output logic asserted,
  output logic transition
);
  logic last;
  logic primed;

  // No edge until one real sample is held, whatever the pin's idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      primed <= 1'b0;
    end else begin
      last <= pin;
      primed <= 1'b1;
    end
  end

  // Any change counts as a wake event, either direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transition <= 1'b0;
      asserted <= 1'b0;
    end else begin
      transition <= enable && primed && (pin != last);
      asserted <= enable && (pin == polarity);
    end
  end
endmodule

// File: hw/port_fifo_pin_mux.sv
// Purpose: Function select for port A pins 2..7 and port B pins 0..2
// Assumes: One clock, pins synchronous, external master drives FIFO side
// Notes: Pad outputs registered, so select changes take one cycle
`timescale 1ns/100ps
// Behaviour
// [R1] Config field selects port or FIFO function
// [R2] FIFO output enable is input, programmable polarity
// [R3] Second wake pin enabled and polarity set
// [R4] Suspended wake transition restarts oscillator, interrupts
// [R5] Asserted enabled wake pin blocks suspend
// [R6] Pin 3 function from wake and OE bits
// [R7] FIFO select pins are inputs in FIFO mode
// [R8] Packet commit is input, programmable polarity
// [R9] Pin 7 is port, status flag, or chip select
// [R10] Deasserted chip select blocks all FIFO strobes
// [R11] Port B low pins are port or data bus
// [R12] Port-mode pins act as bidirectional I/O
// [R13] Pins float in reset, then port inputs
// [R14] One config value is plain port mode
module port_fifo_pin_mux (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire pin_mux_pkg::mux_cfg_s CFG,
  input wire logic [7:0] PA_IN,
  input wire logic [7:0] PA_DATA,
  output logic [7:0] PA_OUT,
  output logic [7:0] PA_OE,
  input wire logic [2:0] PB_IN,
  input wire logic [2:0] PB_DATA,
  output logic [2:0] PB_OUT,
  output logic [2:0] PB_OE,
  output logic [7:0] PA_READ,
  output logic [2:0] PB_READ,
  input wire logic [2:0] FD_OUT_DATA,
  input wire logic FD_DRIVE_REQ,
  output logic [2:0] FD_IN_DATA,
  input wire logic FOURTH_STATUS_FLAG,
  output pin_mux_pkg::fifo_ctl_s FIFO_CTL,
  output logic FIFO_MODE,
  output logic FD_OUTPUT_EN,
  output logic PACKET_COMMIT,
  output logic FIFO_STROBE_OK,
  input wire logic CPU_SUSPENDED,
  output logic OSC_RESTART,
  output logic WAKE_IRQ,
  output logic SUSPEND_INHIBIT
);
  import pin_mux_pkg::*;

  typedef enum logic [1:0] {PA7_PORT, PA7_FLAG, PA7_CS} pa7_fn_e;

  logic fifo_mode;
  logic pa3_is_wake;
  logic wake_asserted;
  logic wake_transition;
  pa7_fn_e pa7_fn;
  logic [7:0] next_pa_oe;
  logic [7:0] next_pa_out;
  logic [2:0] next_pb_oe;
  logic [2:0] next_pb_out;
  logic cs_active;
  logic cs_ok;

  // [R14] Ports mode decode
  function automatic logic is_fifo(input logic [1:0] f);
    return f != IFC_PORTS;
  endfunction

  // [R1] Interface field select
  assign fifo_mode = is_fifo(CFG.interface_config_field);
  // [R6] Wake select with pin as input
  assign pa3_is_wake = CFG.wake_ctrl[WAKE_PA3_SEL_BIT] &&
                       !CFG.porta_output_enable_reg[PA3_OE_BIT];

  // [R9] Pin 7 function choice
  always_comb begin
    if (!is_fifo(CFG.interface_config_field)) begin
      pa7_fn = PA7_PORT;
    end else if (CFG.porta_function_config[PA7_CFG_BIT]) begin
      pa7_fn = PA7_FLAG;
    end else if (CFG.interface_config_field == IFC_SLAVE) begin
      pa7_fn = PA7_CS;
    end else begin
      pa7_fn = PA7_PORT;
    end
  end

  assign cs_active = pa7_fn == PA7_CS;
  // [R10] Chip select gating
  assign cs_ok = !cs_active || !PA_IN[PA_PIN7];

  // [R12] Port-mode pins default to software direction
  always_comb begin
    next_pa_oe = CFG.porta_output_enable_reg;
    next_pa_out = PA_DATA;
    if (fifo_mode) begin
      // [R2] Output enable pin input only
      next_pa_oe[PA_PIN2] = 1'b0;
      // [R7] Select pins input only
      next_pa_oe[PA_PIN4] = 1'b0;
      next_pa_oe[PA_PIN5] = 1'b0;
      // [R8] Commit pin input only
      next_pa_oe[PA_PIN6] = 1'b0;
    end
    if (pa3_is_wake) begin
      next_pa_oe[PA_PIN3] = 1'b0;
    end
    unique case (pa7_fn)
      PA7_PORT: begin
      end
      PA7_FLAG: begin
        next_pa_oe[PA_PIN7] = 1'b1;
        next_pa_out[PA_PIN7] = FOURTH_STATUS_FLAG;
      end
      PA7_CS: begin
        next_pa_oe[PA_PIN7] = 1'b0;
      end
    endcase
  end

  // [R11] Port B low pins or data bus
  always_comb begin
    if (fifo_mode) begin
      next_pb_oe = {PB_LOW_BITS{FD_DRIVE_REQ && cs_ok}};
      next_pb_out = FD_OUT_DATA;
    end else begin
      next_pb_oe = CFG.portb_output_enable[PB_LOW_BITS-1:0];
      next_pb_out = PB_DATA;
    end
  end

  // [R13] All covered pins float under reset
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PA_OE <= RESET_BYTE;
      PA_OUT <= RESET_BYTE;
      PB_OE <= 3'h0;
      PB_OUT <= 3'h0;
    end else begin
      PA_OE <= next_pa_oe;
      PA_OUT <= next_pa_out;
      PB_OE <= next_pb_oe;
      PB_OUT <= next_pb_out;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PA_READ <= RESET_BYTE;
      PB_READ <= 3'h0;
      FD_IN_DATA <= 3'h0;
    end else begin
      PA_READ <= PA_IN;
      PB_READ <= PB_IN;
      FD_IN_DATA <= fifo_mode ? PB_IN : 3'h0;
    end
  end

  // [R2] Raw FIFO control copies and polarity-corrected FIFO strobes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FIFO_CTL <= '0;
      FIFO_MODE <= 1'b0;
      FD_OUTPUT_EN <= 1'b0;
      PACKET_COMMIT <= 1'b0;
      FIFO_STROBE_OK <= 1'b0;
    end else begin
      FIFO_CTL.slave_output_enable_in <= PA_IN[PA_PIN2];
      FIFO_CTL.fifo_select_bit0 <= PA_IN[PA_PIN4];
      FIFO_CTL.fifo_select_bit1 <= PA_IN[PA_PIN5];
      FIFO_CTL.packet_commit_in <= PA_IN[PA_PIN6];
      FIFO_CTL.slave_chip_select_n <= cs_active ? PA_IN[PA_PIN7] : 1'b0;
      FIFO_MODE <= fifo_mode;
      FIFO_STROBE_OK <= fifo_mode && cs_ok;
      // [R10] Strobes blocked without select
      FD_OUTPUT_EN <= fifo_mode && cs_ok &&
        (PA_IN[PA_PIN2] == CFG.fifo_pin_polarity_reg[POL_OE_BIT]);
      // [R8] Commit strobe with polarity
      PACKET_COMMIT <= fifo_mode && cs_ok &&
        (PA_IN[PA_PIN6] == CFG.fifo_pin_polarity_reg[POL_COMMIT_BIT]);
    end
  end

  // [R3] Wake source enable and polarity
  wake_detect u_wake (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(PA_IN[PA_PIN3]),
    .enable(pa3_is_wake && CFG.wake_ctrl[WAKE_EN_BIT]),
    .polarity(CFG.wake_ctrl[WAKE_POL_BIT]),
    .asserted(wake_asserted),
    .transition(wake_transition)
  );

  // [R4] Wake from suspend, [R5] suspend hold-off
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OSC_RESTART <= 1'b0;
      WAKE_IRQ <= 1'b0;
      SUSPEND_INHIBIT <= 1'b0;
    end else begin
      OSC_RESTART <= CPU_SUSPENDED && wake_transition;
      WAKE_IRQ <= CPU_SUSPENDED && wake_transition;
      SUSPEND_INHIBIT <= wake_asserted;
    end
  end

  // Wake source checks
  a_wake_irq_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R4]
    (CPU_SUSPENDED && wake_transition) |=> WAKE_IRQ && OSC_RESTART)
    else $error("wake transition did not raise interrupt");
  a_no_wake_awake: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R4]
    !CPU_SUSPENDED |=> !WAKE_IRQ && !OSC_RESTART)
    else $error("wake pulse while not suspended");
  a_irq_osc_pair: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R4]
    WAKE_IRQ == OSC_RESTART)
    else $error("interrupt and oscillator restart differ");
  a_wake_needs_en: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R3]
    !CFG.wake_ctrl[WAKE_EN_BIT] |-> ##2 !SUSPEND_INHIBIT || CFG.wake_ctrl[WAKE_EN_BIT])
    else $error("inhibit without wake enable");
  a_wake_off_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R3]
    !CFG.wake_ctrl[WAKE_EN_BIT] |=> !wake_transition && !wake_asserted)
    else $error("wake source active while disabled");
  a_wake_polarity: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R3]
    (PA_IN[PA_PIN3] != CFG.wake_ctrl[WAKE_POL_BIT]) |=> !wake_asserted)
    else $error("wake asserted at inactive level");
  a_suspend_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R5]
    wake_asserted |=> SUSPEND_INHIBIT)
    else $error("asserted wake pin did not inhibit suspend");
  a_inhibit_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R5]
    !wake_asserted |=> !SUSPEND_INHIBIT)
    else $error("suspend inhibited without asserted wake pin");
  a_wake_pin_input: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R6]
    pa3_is_wake |=> !PA_OE[PA_PIN3])
    else $error("wake pin driven");
  a_pa3_port: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R6]
    !CFG.wake_ctrl[WAKE_PA3_SEL_BIT] |=>
      PA_OE[PA_PIN3] == $past(CFG.porta_output_enable_reg[PA3_OE_BIT]))
    else $error("pin 3 direction not from output enable");

  // FIFO control pin checks
  a_mode_register: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R1]
    fifo_mode |=> FIFO_MODE)
    else $error("FIFO mode flag not raised");
  a_port_no_strobe: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R14]
    !fifo_mode |=> !FIFO_MODE && !FD_OUTPUT_EN && !PACKET_COMMIT && !FIFO_STROBE_OK)
    else $error("FIFO strobe in port mode");
  a_oe_pin_input: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R7]
    fifo_mode |=> !PA_OE[PA_PIN2] && !PA_OE[PA_PIN4] && !PA_OE[PA_PIN5])
    else $error("FIFO input pin driven");
  a_select_copy: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R7]
    1'b1 |=> FIFO_CTL.fifo_select_bit0 == $past(PA_IN[PA_PIN4]) &&
      FIFO_CTL.fifo_select_bit1 == $past(PA_IN[PA_PIN5]))
    else $error("FIFO select bits not passed");
  a_oe_polarity: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R2]
    (PA_IN[PA_PIN2] != CFG.fifo_pin_polarity_reg[POL_OE_BIT]) |=> !FD_OUTPUT_EN)
    else $error("output enable at inactive level");
  a_ctl_copy: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R2]
    1'b1 |=> FIFO_CTL.slave_output_enable_in == $past(PA_IN[PA_PIN2]) &&
      FIFO_CTL.packet_commit_in == $past(PA_IN[PA_PIN6]))
    else $error("raw control copy wrong");
  a_commit_input: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R8]
    PACKET_COMMIT |-> !PA_OE[PA_PIN6] && $past(fifo_mode))
    else $error("commit while pin driven or port mode");
  a_commit_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R8]
    (PA_IN[PA_PIN6] != CFG.fifo_pin_polarity_reg[POL_COMMIT_BIT]) |=> !PACKET_COMMIT)
    else $error("commit at inactive level");

  // Pin 7 and chip select checks
  a_cs_blocks: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R10]
    (cs_active && PA_IN[PA_PIN7]) |=> !FD_OUTPUT_EN && !PACKET_COMMIT)
    else $error("strobe passed without chip select");
  a_bus_blocked: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R10]
    (cs_active && PA_IN[PA_PIN7]) |=> PB_OE == 3'h0 && !FIFO_STROBE_OK)
    else $error("data bus driven without chip select");
  a_cs_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R10]
    !cs_active |=> !FIFO_CTL.slave_chip_select_n)
    else $error("chip select copy while unused");
  a_flag_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R9]
    (pa7_fn == PA7_FLAG) |=>
      PA_OE[PA_PIN7] && PA_OUT[PA_PIN7] == $past(FOURTH_STATUS_FLAG))
    else $error("status flag not driven on pin 7");
  a_cs_input: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R9]
    (pa7_fn == PA7_CS) |=> !PA_OE[PA_PIN7] &&
      FIFO_CTL.slave_chip_select_n == $past(PA_IN[PA_PIN7]))
    else $error("chip select pin not an input");
  a_pa7_port: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R9]
    (pa7_fn == PA7_PORT) |=>
      PA_OE[PA_PIN7] == $past(CFG.porta_output_enable_reg[PA_PIN7]))
    else $error("pin 7 port direction not followed");

  // Data bus and port checks
  a_bus_drive: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R11]
    (fifo_mode && FD_DRIVE_REQ && cs_ok) |=> PB_OE == 3'h7 && PB_OUT == $past(FD_OUT_DATA))
    else $error("data bus not driven on request");
  a_bus_capture: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R11]
    fifo_mode |=> FD_IN_DATA == $past(PB_IN))
    else $error("data bus not captured");
  a_portb_select: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R11]
    !fifo_mode |=> PB_OUT == $past(PB_DATA) && FD_IN_DATA == 3'h0)
    else $error("port B data not passed in port mode");
  a_portb_dir: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R12]
    !fifo_mode |=> PB_OE == $past(CFG.portb_output_enable[PB_LOW_BITS-1:0]))
    else $error("port B direction not followed");
  a_port_mode_io: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R12]
    (!fifo_mode && !pa3_is_wake) |=> PA_OE == $past(CFG.porta_output_enable_reg))
    else $error("port direction not followed");
  a_port_data: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R12]
    (pa7_fn != PA7_FLAG) |=> PA_OUT == $past(PA_DATA))
    else $error("port A data not passed");
  a_read_back: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R12]
    1'b1 |=> PA_READ == $past(PA_IN) && PB_READ == $past(PB_IN))
    else $error("pad read-back wrong");
  a_reset_float: assert property (@(posedge CORE_CLK) // [R13]
    !RST_N |-> PA_OE == RESET_BYTE && PB_OE == 3'h0)
    else $error("pin driven during reset");
endmodule

// File: testbench/fifo_master_model.sv
// Purpose: External FIFO master on the far side of the pads
// Assumes: Drive values and enables come from the bench
// Notes: Undriven pads wander each cycle, so a missing driver shows
`timescale 1ns/100ps
module fifo_master_model #(parameter int W = 8) (
  input wire logic clk,
  input wire logic [W-1:0] dut_out,
  input wire logic [W-1:0] dut_oe,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] en,
  output logic [W-1:0] pad
);
  logic [W-1:0] wander = '0;
  always_ff @(posedge clk) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad[i] = dut_oe[i] ? dut_out[i] : (en[i] ? drv[i] : wander[i]);
    end
  end
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the port A/B pin multiplexer
// Assumes: Outputs settle within four cycles of an input change
// Notes: Port A pins 0 and 1 lie outside this block
`timescale 1ns/100ps
module tb_top;
  import pin_mux_pkg::*;
  logic CORE_CLK = 0;
  logic RST_N = 1;
  mux_cfg_s cfg = '0;
  logic [7:0] pa_data = '0, m_drv = '0, m_en = '0, pa_out, pa_oe, pa_in, pa_read;
  logic [2:0] pb_data = '0, fd_out = '0, b_drv = '0, b_en = '0;
  logic [2:0] pb_out, pb_oe, pb_in, pb_read, fd_in;
  logic fd_req = 0, flag = 0, susp = 0;
  logic fmode, fd_oe, commit, strobe_ok, osc, irq, inhibit;
  fifo_ctl_s ctl;
  int failures = 0, checks = 0, cycles = 0, pulses = 0;

  port_fifo_pin_mux uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CFG(cfg),
    .PA_IN(pa_in), .PA_DATA(pa_data), .PA_OUT(pa_out), .PA_OE(pa_oe),
    .PB_IN(pb_in), .PB_DATA(pb_data), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PA_READ(pa_read), .PB_READ(pb_read), .FD_OUT_DATA(fd_out),
    .FD_DRIVE_REQ(fd_req), .FD_IN_DATA(fd_in), .FOURTH_STATUS_FLAG(flag),
    .FIFO_CTL(ctl), .FIFO_MODE(fmode), .FD_OUTPUT_EN(fd_oe),
    .PACKET_COMMIT(commit), .FIFO_STROBE_OK(strobe_ok),
    .CPU_SUSPENDED(susp), .OSC_RESTART(osc), .WAKE_IRQ(irq),
    .SUSPEND_INHIBIT(inhibit));
  fifo_master_model #(.W(8)) pa_far (.clk(CORE_CLK), .dut_out(pa_out),
    .dut_oe(pa_oe), .drv(m_drv), .en(m_en), .pad(pa_in));
  fifo_master_model #(.W(3)) pb_far (.clk(CORE_CLK), .dut_out(pb_out),
    .dut_oe(pb_oe), .drv(b_drv), .en(b_en), .pad(pb_in));

  always #5 CORE_CLK = ~CORE_CLK;

  task automatic tally_and_finish;
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, and one-cycle wake pulses counted as they pass
  always @(posedge CORE_CLK) begin
    cycles++;
    pulses = pulses + (irq === 1'b1) + (osc === 1'b1);
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (4) @(negedge CORE_CLK);
  endtask

  initial begin
    // Reset lands before the first edge, so no edge sees unreset flops
    #1 RST_N = 0;
    cfg.porta_output_enable_reg = 8'hFC;
    repeat (4) @(negedge CORE_CLK);
    chk(pa_oe, 8'h00);
    chk(pb_oe, 3'h0);
    cfg = '0;
    RST_N = 1;
    @(negedge CORE_CLK);
    chk(pa_oe[7:2], 6'h00);
    cfg.porta_output_enable_reg = 8'hA4;
    cfg.portb_output_enable = 8'h05;
    pa_data = 8'hC4;
    pb_data = 3'h6;
    m_drv = 8'h48;
    m_en = 8'hFC;
    settle;
    chk(pa_oe[7:2], 6'h29);
    chk(pa_out[7:2] & 6'h29, pa_data[7:2] & 6'h29);
    chk(pa_read[7:2], (pa_data[7:2] & 6'h29) | (m_drv[7:2] & 6'h16));
    chk(pb_oe, 3'h5);
    chk(pb_out & 3'h5, pb_data & 3'h5);
    chk(pb_read & 3'h5, pb_data & 3'h5);
    chk(fd_in, 3'h0);
    for (int m = 0; m < 4; m++) begin
      cfg.interface_config_field = 2'(m);
      settle;
      chk(fmode, 8'(m != 0));
    end
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 2; a++) begin
        cfg.fifo_pin_polarity_reg = p ? 8'h30 : 8'h00;
        m_drv = {1'b0, a[0], 2'b10, 1'b0, a[0], 2'b00};
        settle;
        chk(fd_oe, 8'(a == p));
        chk(commit, 8'(a == p));
        chk(pa_oe[7:2], 6'h00);
      end
    end
    chk(ctl.fifo_select_bit1, 1'b1);
    chk(ctl.fifo_select_bit0, 1'b0);
    chk(ctl.slave_output_enable_in, 1'b1);
    chk(ctl.packet_commit_in, 1'b1);
    chk(strobe_ok, 1'b1);
    m_drv[7] = 1'b1;
    fd_req = 1;
    fd_out = 3'h5;
    settle;
    chk(ctl.slave_chip_select_n, 1'b1);
    chk(fd_oe, 1'b0);
    chk(commit, 1'b0);
    chk(strobe_ok, 1'b0);
    chk(pb_oe, 3'h0);
    m_drv[7] = 1'b0;
    settle;
    chk(pb_oe, 3'h7);
    chk(pb_out, 3'h5);
    fd_req = 0;
    b_en = 3'h7;
    b_drv = 3'h3;
    settle;
    chk(pb_oe, 3'h0);
    chk(fd_in, 3'h3);
    chk(pb_read, 3'h3);
    cfg.interface_config_field = IFC_MASTER;
    cfg.porta_function_config = 8'h80;
    for (int f = 0; f < 2; f++) begin
      flag = f[0];
      settle;
      chk(pa_oe[7], 1'b1);
      chk(pa_out[7], f[0]);
    end
    cfg.interface_config_field = IFC_PORTS;
    cfg.porta_output_enable_reg = 8'h08;
    cfg.wake_ctrl = 8'h80;
    settle;
    chk(pa_oe[3], 1'b1);
    cfg.porta_output_enable_reg = 8'h00;
    cfg.wake_ctrl = 8'h92;
    susp = 1;
    m_drv[3] = 1'b0;
    settle;
    chk(pa_oe[3], 1'b0);
    chk(inhibit, 1'b0);
    pulses = 0;
    m_drv[3] = 1'b1;
    settle;
    chk(8'(pulses), 8'h02);
    chk(inhibit, 1'b1);
    cfg.wake_ctrl = 8'h82;
    settle;
    chk(inhibit, 1'b0);
    cfg.wake_ctrl = 8'h80;
    pulses = 0;
    m_drv[3] = 1'b0;
    settle;
    chk(8'(pulses), 8'h00);
    cfg.porta_output_enable_reg = 8'hFC;
    RST_N = 0;
    @(negedge CORE_CLK);
    chk(pa_oe, 8'h00);
    chk(pb_oe, 3'h0);
    tally_and_finish();
  end
endmodule
